// File: include/gxp_pkg.sv
// Constants for the 8-line I/O expander port: register map, reset values,
// field positions, oscillator and serial bus settings.
// Assumes a single 20 MHz core clock and a two-wire serial host bus.
package gxp_pkg;

	// Core clock and internal oscillator
	localparam int unsigned CLK_HZ      = 20_000_000;
	localparam int unsigned INT_OSC_HZ  = 2_000_000;
	// Half periods of the internal oscillator, counted in core cycles
	localparam int unsigned INT_HALF_DIV = CLK_HZ / (2 * INT_OSC_HZ);
	localparam logic [3:0]  INT_HALF_MAX = 4'(INT_HALF_DIV - 1);

	// Register offsets
	localparam logic [7:0] ADDR_OPEN_DRAIN  = 8'h05;
	localparam logic [7:0] ADDR_POLARITY    = 8'h06;
	localparam logic [7:0] ADDR_DIRECTION   = 8'h07;
	localparam logic [7:0] ADDR_PIN_DATA    = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK    = 8'h09;
	localparam logic [7:0] ADDR_SENSE_UPPER = 8'h0a;
	localparam logic [7:0] ADDR_SENSE_LOWER = 8'h0b;
	localparam logic [7:0] ADDR_IRQ_SOURCE  = 8'h0c;
	localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h0d;
	localparam logic [7:0] ADDR_LEVEL_SHIFT = 8'h0e;
	localparam logic [7:0] ADDR_CLOCK_CFG   = 8'h0f;
	localparam logic [7:0] ADDR_MISC_CFG    = 8'h10;

	// Reset values
	localparam logic [7:0] RST_OPEN_DRAIN  = 8'h00;
	localparam logic [7:0] RST_POLARITY    = 8'h00;
	localparam logic [7:0] RST_DIRECTION   = 8'hff;
	localparam logic [7:0] RST_PIN_DATA    = 8'hff;
	localparam logic [7:0] RST_IRQ_MASK    = 8'hff;
	localparam logic [7:0] RST_SENSE       = 8'h00;
	localparam logic [7:0] RST_FLAGS       = 8'h00;
	localparam logic [7:0] RST_LEVEL_SHIFT = 8'h00;
	localparam logic [7:0] RST_CLOCK_CFG   = 8'h00;
	localparam logic [7:0] RST_MISC_CFG    = 8'h00;
	localparam logic [7:0] READ_UNMAPPED   = 8'h00;

	// Clock register fields
	localparam int unsigned CLK_SRC_LSB   = 5;
	localparam int unsigned CLK_DIR_BIT   = 4;
	localparam logic [1:0]  SRC_OFF       = 2'h0;
	localparam logic [1:0]  SRC_EXT       = 2'h1;
	localparam logic [1:0]  SRC_INT       = 2'h2;
	localparam logic [3:0]  CLKOUT_LOW    = 4'h0;
	localparam logic [3:0]  CLKOUT_HIGH   = 4'hf;

	// Miscellaneous register fields
	localparam int unsigned MISC_FADE_BIT     = 7;
	localparam int unsigned MISC_NO_AUTOINC   = 1;
	localparam int unsigned MISC_NO_AUTOCLEAR = 0;

	// Edge sensitivity codes
	localparam logic [1:0] EDGE_NONE    = 2'h0;
	localparam logic [1:0] EDGE_RISING  = 2'h1;
	localparam logic [1:0] EDGE_FALLING = 2'h2;
	localparam logic [1:0] EDGE_BOTH    = 2'h3;

	// Serial bus framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [6:0] DEF_SLAVE_ADDR = 7'h3e; // Arbitrary default address

	// Serial slave states
	typedef enum logic [8:0] {
		SB_IDLE     = 9'h001,
		SB_ADDR     = 9'h002,
		SB_ADDR_ACK = 9'h004,
		SB_REG      = 9'h008,
		SB_REG_ACK  = 9'h010,
		SB_WDATA    = 9'h020,
		SB_WACK     = 9'h040,
		SB_RDATA    = 9'h080,
		SB_RACK     = 9'h100
	} gxp_bus_state_t;

endpackage

// File: hdl/gxp_port.sv
// Eight-line I/O expander port with edge events, interrupt flags, clock pin
// management, reached by a host over a two-wire serial register bus.
// Assumes pins and serial bus lines are asynchronous; they are synchronised here.
// Summary of operation
// - Output line drives push-pull when open-drain bit is 0, else open-drain
// - Polarity bit 1 inverts pin to data relation for inputs and outputs
// - Direction bit 0 means output, 1 means input; all reset to 1
// - Data writes set levels on output lines; input lines stay undriven
// - Data reads return actual pin levels after polarity, whatever the direction
// - Only lines with mask bit 0 may raise the interrupt; masks reset to 1
// - Two-bit edge code per line: none, rising, falling or both
// - Upper sense register holds lines 7..4, lower 3..0, highest in bits 7:6
// - Unmasked matching edge sets source bit; interrupt low while any is set
// - Writing 1 to source bit clears it and its event bit
// - Interrupt output returns high once all source bits are clear
// - Matching edge sets event bit on every line regardless of mask
// - Writing 1 to event bit clears it and its source bit
// - Changing a line's edge code clears its event and source bits
// - Level-shift register holds a 2-bit mode per line pair; 00 is off
// - Clock bits 6:5 pick oscillator: off, external, internal 2 MHz, reserved
// - Clock bit 4 makes oscillator pin input (0) or clock output (1)
// - Clock bits 3:0: 0 low, F high, else oscillator divided by 2^(n-1)
// - Misc bit 7 selects linear or logarithmic fading for line 7
// - With auto-clear bit 0, a data read also clears all source bits
`timescale 1ns/100ps

module gxp_port
	import gxp_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = DEF_SLAVE_ADDR
) (
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda_out,
	output logic            o_sda_oe,
	input  wire logic [7:0] i_io_pin,
	output logic      [7:0] o_io_out,
	output logic      [7:0] o_io_oe,
	input  wire logic       i_osc_pin,
	output logic            o_osc_pin_out,
	output logic            o_osc_pin_oe,
	output logic            o_irq_out_n,
	output logic      [7:0] o_level_shift_mode,
	output logic      [1:0] o_osc_source,
	output logic            o_fade_log_mode
);

	// Registers
	logic [7:0] open_drain_enable_reg;
	logic [7:0] polarity_invert_reg;
	logic [7:0] direction_select_reg;
	logic [7:0] pin_data_reg;
	logic [7:0] irq_mask_reg;
	logic [7:0] edge_sense_upper_reg;
	logic [7:0] edge_sense_lower_reg;
	logic [7:0] irq_source_flags_reg;
	logic [7:0] event_flags_reg;
	logic [7:0] level_shift_mode_reg;
	logic [7:0] clock_config_reg;
	logic [7:0] misc_config_reg;

	// Synchronisers and edge history
	logic [7:0] io_meta_reg;
	logic [7:0] io_sync_reg;
	logic [7:0] data_prev_reg;
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic [2:0] osc_sync_reg;

	// Serial slave state
	gxp_bus_state_t bus_state_reg;
	logic [7:0]     shift_reg;
	logic [7:0]     tx_reg;
	logic [3:0]     bit_cnt_reg;
	logic [7:0]     ptr_reg;
	logic           rw_reg;
	logic           nack_reg;
	logic           wr_en_reg;
	logic [7:0]     wr_addr_reg;
	logic [7:0]     wr_data_reg;
	logic           data_read_reg;

	// Oscillator state
	logic [3:0]  int_div_reg;
	logic [13:0] osc_cnt_reg;

	// Decoded values
	logic [7:0]  pin_value;
	logic [15:0] sense_all;
	logic [15:0] sense_new;
	logic [7:0]  edge_hit;
	logic [7:0]  sense_changed;
	logic [7:0]  flag_clear;
	logic        scl_rise;
	logic        scl_fall;
	logic        bus_start;
	logic        bus_stop;
	logic        half_tick;
	logic [1:0]  osc_src;
	logic [7:0]  ptr_step;

	// Register read decode, used for first and following bytes of a read
	function automatic logic [7:0] reg_read(input logic [7:0] addr);
		unique case (addr)
			ADDR_OPEN_DRAIN:  reg_read = open_drain_enable_reg;
			ADDR_POLARITY:    reg_read = polarity_invert_reg;
			ADDR_DIRECTION:   reg_read = direction_select_reg;
			ADDR_PIN_DATA:    reg_read = pin_value;
			ADDR_IRQ_MASK:    reg_read = irq_mask_reg;
			ADDR_SENSE_UPPER: reg_read = edge_sense_upper_reg;
			ADDR_SENSE_LOWER: reg_read = edge_sense_lower_reg;
			ADDR_IRQ_SOURCE:  reg_read = irq_source_flags_reg;
			ADDR_EVENT_FLAGS: reg_read = event_flags_reg;
			ADDR_LEVEL_SHIFT: reg_read = level_shift_mode_reg;
			ADDR_CLOCK_CFG:   reg_read = clock_config_reg;
			ADDR_MISC_CFG:    reg_read = misc_config_reg;
			default:          reg_read = READ_UNMAPPED;
		endcase
	endfunction

	// Write strobe for one register address
	function automatic logic wr_hit(input logic [7:0] addr);
		wr_hit = wr_en_reg && (wr_addr_reg == addr);
	endfunction

	// Two flops before any logic reads the pins
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			io_meta_reg  <= 8'h00;
			io_sync_reg  <= 8'h00;
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			osc_sync_reg <= 3'h0;
		end else begin
			io_meta_reg  <= i_io_pin;
			io_sync_reg  <= io_meta_reg;
			scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
			sda_sync_reg <= {sda_sync_reg[1:0], i_sda};
			osc_sync_reg <= {osc_sync_reg[1:0], i_osc_pin};
		end
	end

	// Pin levels as seen through polarity
	assign pin_value = io_sync_reg ^ polarity_invert_reg;
	assign sense_all = {edge_sense_upper_reg, edge_sense_lower_reg};
	always_comb sense_new = {wr_hit(ADDR_SENSE_UPPER) ? wr_data_reg : edge_sense_upper_reg,
	                    wr_hit(ADDR_SENSE_LOWER) ? wr_data_reg : edge_sense_lower_reg};

	// Per-line edge match and sense change
	generate
		for (genvar i = 0; i < 8; i++) begin : g_line
			logic rise;
			logic fall;
			assign rise = pin_value[i] & ~data_prev_reg[i];
			assign fall = ~pin_value[i] & data_prev_reg[i];
			assign edge_hit[i] = (rise & sense_all[2*i]) | (fall & sense_all[2*i+1]);
			assign sense_changed[i] = sense_new[2*i+1 -: 2] != sense_all[2*i+1 -: 2];
		end
	endgenerate

	// Either flag register clears the pair, as does a sense change
	always_comb flag_clear = (wr_hit(ADDR_IRQ_SOURCE) ? wr_data_reg : 8'h00)
	                  | (wr_hit(ADDR_EVENT_FLAGS) ? wr_data_reg : 8'h00)
	                  | sense_changed;

	// Edge history
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			data_prev_reg <= 8'h00;
		end else begin
			data_prev_reg <= pin_value;
		end
	end

	// Event flags; a new edge wins over a clear in the same cycle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			event_flags_reg <= RST_FLAGS;
		end else begin
			event_flags_reg <= (event_flags_reg & ~flag_clear) | edge_hit;
		end
	end

	// Interrupt source flags; data read clears all unless auto-clear is off
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_source_flags_reg <= RST_FLAGS;
		end else if (data_read_reg && !misc_config_reg[MISC_NO_AUTOCLEAR]) begin
			irq_source_flags_reg <= edge_hit & ~irq_mask_reg;
		end else begin
			irq_source_flags_reg <= (irq_source_flags_reg & ~flag_clear)
			                      | (edge_hit & ~irq_mask_reg);
		end
	end

	// Interrupt pin follows the source flags one cycle later
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_irq_out_n <= 1'b1;
		end else begin
			o_irq_out_n <= ~|irq_source_flags_reg;
		end
	end

	// Configuration registers written from the serial bus
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			open_drain_enable_reg <= RST_OPEN_DRAIN;
			polarity_invert_reg   <= RST_POLARITY;
			direction_select_reg  <= RST_DIRECTION;
			pin_data_reg          <= RST_PIN_DATA;
			irq_mask_reg          <= RST_IRQ_MASK;
			edge_sense_upper_reg  <= RST_SENSE;
			edge_sense_lower_reg  <= RST_SENSE;
			level_shift_mode_reg  <= RST_LEVEL_SHIFT;
			clock_config_reg      <= RST_CLOCK_CFG;
			misc_config_reg       <= RST_MISC_CFG;
		end else if (wr_en_reg) begin
			unique case (wr_addr_reg)
				ADDR_OPEN_DRAIN:  open_drain_enable_reg <= wr_data_reg;
				ADDR_POLARITY:    polarity_invert_reg   <= wr_data_reg;
				ADDR_DIRECTION:   direction_select_reg  <= wr_data_reg;
				ADDR_PIN_DATA:    pin_data_reg          <= wr_data_reg;
				ADDR_IRQ_MASK:    irq_mask_reg          <= wr_data_reg;
				ADDR_SENSE_UPPER: edge_sense_upper_reg  <= wr_data_reg;
				ADDR_SENSE_LOWER: edge_sense_lower_reg  <= wr_data_reg;
				ADDR_LEVEL_SHIFT: level_shift_mode_reg  <= wr_data_reg;
				ADDR_CLOCK_CFG:   clock_config_reg      <= wr_data_reg;
				ADDR_MISC_CFG:    misc_config_reg       <= wr_data_reg;
				default: ;
			endcase
		end
	end

	// Pin drivers; open-drain lines only ever pull low
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_io_out <= 8'h00;
			o_io_oe  <= 8'h00;
		end else begin
			o_io_out <= pin_data_reg ^ polarity_invert_reg;
			o_io_oe  <= ~direction_select_reg
			          & ~(open_drain_enable_reg & (pin_data_reg ^ polarity_invert_reg));
		end
	end

	// Mode outputs straight from their registers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_level_shift_mode <= RST_LEVEL_SHIFT;
			o_fade_log_mode    <= 1'b0;
			o_osc_source       <= SRC_OFF;
		end else begin
			o_level_shift_mode <= level_shift_mode_reg;
			o_fade_log_mode    <= misc_config_reg[MISC_FADE_BIT];
			o_osc_source       <= osc_src;
		end
	end

	// Oscillator half periods: internal divider or both external edges
	assign osc_src   = clock_config_reg[CLK_SRC_LSB +: 2];
	assign half_tick = (osc_src == SRC_INT) ? (int_div_reg == INT_HALF_MAX)
	                 : (osc_src == SRC_EXT) ? (!clock_config_reg[CLK_DIR_BIT]
	                                           && (osc_sync_reg[2] != osc_sync_reg[1]))
	                 : 1'b0;

	// Internal oscillator divider runs only while selected
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			int_div_reg <= 4'h0;
		end else if (osc_src != SRC_INT || int_div_reg == INT_HALF_MAX) begin
			int_div_reg <= 4'h0;
		end else begin
			int_div_reg <= int_div_reg + 4'h1;
		end
	end

	// Bit k of this counter toggles at the oscillator rate over 2^k
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			osc_cnt_reg <= 14'h0000;
		end else if (half_tick) begin
			osc_cnt_reg <= osc_cnt_reg + 14'h0001;
		end
	end

	// Clock pin: direction and divided output
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_osc_pin_out <= 1'b0;
			o_osc_pin_oe  <= 1'b0;
		end else begin
			o_osc_pin_oe <= clock_config_reg[CLK_DIR_BIT];
			unique case (clock_config_reg[3:0])
				CLKOUT_LOW:  o_osc_pin_out <= 1'b0;
				CLKOUT_HIGH: o_osc_pin_out <= 1'b1;
				default:     o_osc_pin_out <= osc_cnt_reg[clock_config_reg[3:0] - 4'h1];
			endcase
		end
	end

	// Serial bus conditions from the settled sync stages
	assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
	assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
	assign bus_start = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[1] & sda_sync_reg[2];
	assign bus_stop  = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[1] & ~sda_sync_reg[2];
	assign ptr_step  = misc_config_reg[MISC_NO_AUTOINC] ? ptr_reg : ptr_reg + 8'h01;

	// Serial slave: bits taken on clock rise, data line changed on clock fall
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			bus_state_reg <= SB_IDLE;
			shift_reg     <= 8'h00;
			tx_reg        <= 8'h00;
			bit_cnt_reg   <= 4'h0;
			ptr_reg       <= 8'h00;
			rw_reg        <= 1'b0;
			nack_reg      <= 1'b0;
			o_sda_oe      <= 1'b0;
			wr_en_reg     <= 1'b0;
			wr_addr_reg   <= 8'h00;
			wr_data_reg   <= 8'h00;
			data_read_reg <= 1'b0;
		end else begin
			wr_en_reg     <= 1'b0;
			data_read_reg <= 1'b0;
			if (bus_start) begin
				bus_state_reg <= SB_ADDR;
				bit_cnt_reg   <= 4'h0;
				o_sda_oe      <= 1'b0;
			end else if (bus_stop) begin
				bus_state_reg <= SB_IDLE;
				o_sda_oe      <= 1'b0;
			end else if (scl_rise) begin
				shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]};
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				nack_reg    <= sda_sync_reg[1];
			end else if (scl_fall) begin
				unique case (bus_state_reg)
					SB_IDLE: ;
					SB_ADDR: begin
						if (bit_cnt_reg == BITS_PER_BYTE) begin
							if (shift_reg[7:1] == SLAVE_ADDR) begin
								rw_reg        <= shift_reg[0];
								o_sda_oe      <= 1'b1;
								bus_state_reg <= SB_ADDR_ACK;
							end else begin
								bus_state_reg <= SB_IDLE;
							end
						end
					end
					SB_ADDR_ACK, SB_RACK: begin
						bit_cnt_reg <= 4'h0;
						if (!rw_reg) begin
							o_sda_oe      <= 1'b0;
							bus_state_reg <= SB_REG;
						end else if (bus_state_reg == SB_RACK && nack_reg) begin
							o_sda_oe      <= 1'b0;
							bus_state_reg <= SB_IDLE;
						end else begin
							tx_reg        <= reg_read(ptr_reg);
							o_sda_oe      <= ~|(reg_read(ptr_reg) >> (BITS_PER_BYTE - 4'h1));
							data_read_reg <= ptr_reg == ADDR_PIN_DATA;
							ptr_reg       <= ptr_step;
							bus_state_reg <= SB_RDATA;
						end
					end
					SB_REG, SB_WDATA: begin
						if (bit_cnt_reg == BITS_PER_BYTE) begin
							o_sda_oe      <= 1'b1;
							bus_state_reg <= (bus_state_reg == SB_REG) ? SB_REG_ACK : SB_WACK;
							if (bus_state_reg == SB_REG) begin
								ptr_reg <= shift_reg;
							end else begin
								wr_en_reg   <= 1'b1;
								wr_addr_reg <= ptr_reg;
								wr_data_reg <= shift_reg;
							end
						end
					end
					SB_REG_ACK: begin
						o_sda_oe      <= 1'b0;
						bit_cnt_reg   <= 4'h0;
						bus_state_reg <= SB_WDATA;
					end
					SB_WACK: begin
						o_sda_oe      <= 1'b0;
						bit_cnt_reg   <= 4'h0;
						ptr_reg       <= ptr_step;
						bus_state_reg <= SB_WDATA;
					end
					SB_RDATA: begin
						if (bit_cnt_reg == BITS_PER_BYTE) begin
							o_sda_oe      <= 1'b0; // Release for the host acknowledge
							bus_state_reg <= SB_RACK;
						end else begin
							tx_reg   <= {tx_reg[6:0], 1'b0};
							o_sda_oe <= ~tx_reg[6];
						end
					end
				endcase
			end
		end
	end

	// Data line is only ever pulled low
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_sda_out <= 1'b0;
		end else begin
			o_sda_out <= 1'b0;
		end
	end

endmodule // gxp_port

// File: tb/gxp_host_model.sv
// Host side of the two-wire register bus: writes and single-byte reads.
// Assumes an open-drain SDA wire resolved by the bench and a pull-up.
`timescale 1ns/100ps

module gxp_host_model
	import gxp_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEF_SLAVE_ADDR
) (
	input  wire logic       i_clk,
	input  wire logic       i_sda,
	output logic            o_scl,
	output logic            o_sda_pull,
	output logic            o_rd_valid,
	output logic      [7:0] o_rd_data,
	output logic            o_nack
);
	int stretch = 0; // Extra low-phase cycles

	// Idle bus: both lines released
	initial begin
		o_scl = 1'b1;
		o_sda_pull = 1'b0;
		o_rd_valid = 1'b0;
		o_rd_data = 8'h00;
		o_nack = 1'b0;
	end

	// All changes land just after a clock edge
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	// SDA is held 5+ cycles on both sides of every SCL edge
	task automatic put_bit(input logic b, output logic s);
		o_sda_pull = !b;
		tick(5 + stretch);
		o_scl = 1'b1;
		tick(6);
		s = i_sda;
		o_scl = 1'b0;
		tick(5);
	endtask

	task automatic send_byte(input logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) put_bit(v[i], s);
		put_bit(1'b1, s);
		if (s !== 1'b0) o_nack = 1'b1; // Sticky, inspected by the bench
	endtask

	task automatic recv_byte(output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, s);
			v[i] = s;
		end
		put_bit(1'b1, s); // Not acknowledged: ends the read
	endtask

	// Start and repeated start share one shape
	task automatic start_c();
		o_sda_pull = 1'b0;
		tick(5);
		o_scl = 1'b1;
		tick(6);
		o_sda_pull = 1'b1;
		tick(6);
		o_scl = 1'b0;
		tick(5);
	endtask

	task automatic stop_c();
		o_sda_pull = 1'b1;
		tick(5);
		o_scl = 1'b1;
		tick(6);
		o_sda_pull = 1'b0;
		tick(10);
	endtask

	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		start_c();
		send_byte({DEV_ADDR, 1'b0});
		send_byte(a);
		send_byte(d);
		stop_c();
	endtask

	// Result is offered for one cycle on o_rd_valid
	task automatic read_reg(input logic [7:0] a);
		logic [7:0] v;
		start_c();
		send_byte({DEV_ADDR, 1'b0});
		send_byte(a);
		start_c();
		send_byte({DEV_ADDR, 1'b1});
		recv_byte(v);
		stop_c();
		o_rd_data = v;
		o_rd_valid = 1'b1;
		tick(1);
		o_rd_valid = 1'b0;
	endtask
endmodule // gxp_host_model

// File: tb/gxp_port_sva.sv
// Timing checks on the expander port pins and its register copy outputs.
// Assumes it is bound onto gxp_port and sees only that module's ports.
`timescale 1ns/100ps

module gxp_port_sva
	import gxp_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	input  wire logic       i_scl,
	input  wire logic [7:0] i_io_pin,
	input  wire logic       o_sda_oe,
	input  wire logic [7:0] o_io_out,
	input  wire logic [7:0] o_io_oe,
	input  wire logic       o_osc_pin_out,
	input  wire logic       o_osc_pin_oe,
	input  wire logic       o_irq_out_n,
	input  wire logic [7:0] o_level_shift_mode,
	input  wire logic [1:0] o_osc_source,
	input  wire logic       o_fade_log_mode
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	// Lines come out of reset as undriven inputs
	AST_DIR_RESET: assert property ($rose(i_nrst) |-> (o_io_oe == 8'h00) [*2])
		else $error("line driven right after reset");
	AST_DATA_RESET: assert property ($rose(i_nrst) |=> o_io_out == 8'hff)
		else $error("output levels not all high after reset");
	// Interrupt only falls after a line actually moved
	AST_IRQ_CAUSE: assert property ($fell(o_irq_out_n) |-> i_io_pin != $past(i_io_pin, 10))
		else $error("interrupt without a line edge");
	// Changing SDA while SCL is high would read as a start or stop
	AST_SDA_SCL_LOW: assert property ($changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 2))
		else $error("sda changed while scl high");
	// Register copies only move on an acknowledged write
	AST_LS_WRITE: assert property ($changed(o_level_shift_mode) |-> ##[0:4] o_sda_oe)
		else $error("level shift mode changed outside a write");
	AST_SRC_WRITE: assert property ($changed(o_osc_source) |-> o_sda_oe [*3])
		else $error("oscillator source changed outside a write");
	AST_OSC_DIR: assert property ($changed(o_osc_pin_oe) |-> o_sda_oe && $past(o_sda_oe))
		else $error("oscillator pin direction changed outside a write");
	AST_FADE_WRITE: assert property ($changed(o_fade_log_mode) |-> ##[0:3] o_sda_oe)
		else $error("fade mode changed outside a write");
	// Divider output on the internal oscillator never toggles faster than its 2 MHz half period
	AST_CLK_RATE: assert property ($changed(o_osc_pin_out) && o_osc_source == SRC_INT &&
		$past(o_osc_source, 2) == SRC_INT |=> $stable(o_osc_pin_out) [*4])
		else $error("clock output toggles too fast");
endmodule // gxp_port_sva

bind gxp_port gxp_port_sva chk_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_scl(i_scl),
	.i_io_pin(i_io_pin), .o_sda_oe(o_sda_oe), .o_io_out(o_io_out), .o_io_oe(o_io_oe),
	.o_osc_pin_out(o_osc_pin_out), .o_osc_pin_oe(o_osc_pin_oe), .o_irq_out_n(o_irq_out_n),
	.o_level_shift_mode(o_level_shift_mode), .o_osc_source(o_osc_source),
	.o_fade_log_mode(o_fade_log_mode));

// File: tb/test_gxp_port.sv
// Self-checking bench for the expander port: registers, pins, events, clock pin.
// Assumes the host model drives the bus; the bench models external line levels.
`timescale 1ns/100ps

module test_gxp_port
	import gxp_pkg::*;
;
	logic       i_clk, i_nrst, scl, host_pull, sda_oe, sda_out, irq_n, osc_out, osc_oe;
	logic       fade, rd_valid, nack;
	logic [1:0] osc_src;
	logic [7:0] ext, io_out, io_oe, ls_mode, rd_data;
	logic [7:0] per [1:3];
	logic [7:0] exp_q [$];
	int         miscompares = 0, tests_run = 0, seed = 10159, cycles = 0;
	// Open-drain bus with pull-up; lines show the outside level when undriven
	wire  logic       sda_wire = !(host_pull || sda_oe);
	wire  logic [7:0] pins = (io_oe & io_out) | (~io_oe & ext);

	gxp_port dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda_wire),
		.o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_io_pin(pins), .o_io_out(io_out),
		.o_io_oe(io_oe), .i_osc_pin(cycles[2]), .o_osc_pin_out(osc_out), .o_osc_pin_oe(osc_oe),
		.o_irq_out_n(irq_n), .o_level_shift_mode(ls_mode), .o_osc_source(osc_src),
		.o_fade_log_mode(fade));
	gxp_host_model host_u (.i_clk(i_clk), .i_sda(sda_wire), .o_scl(scl),
		.o_sda_pull(host_pull), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_nack(nack));

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard; bit 2 clocks the osc pin
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic compare_sig(input string what, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic compare_rd(input logic [7:0] e, input logic [7:0] g);
		compare_sig("register read", e, g);
	endtask

	// Read results are matched in order against the noted values
	always @(posedge i_clk) begin
		if (rd_valid === 1'b1 && exp_q.size() > 0) compare_rd(exp_q.pop_front(), rd_data);
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.write_reg(a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host_u.read_reg(a);
	endtask

	function automatic logic [7:0] rst_of(input logic [7:0] a);
		case (a)
			ADDR_DIRECTION, ADDR_PIN_DATA, ADDR_IRQ_MASK: return 8'hff;
			default: return 8'h00;
		endcase
	endfunction

	task automatic wait_lvl(input logic v, inout int k);
		while (osc_out !== v && k < 400) begin
			cyc(1);
			k++;
		end
	endtask

	// Cycles between two rising edges of the clock output
	task automatic period(output logic [7:0] p);
		int k, k0;
		k = 0;
		wait_lvl(1'b0, k);
		wait_lvl(1'b1, k);
		k0 = k;
		wait_lvl(1'b0, k);
		wait_lvl(1'b1, k);
		p = 8'(k - k0);
		compare_sig("clock running", 8'h01, 8'(k < 400));
	endtask

	initial begin
		logic [7:0] dv, dd, od, pv, eo, ee;
		ext = 8'hff;
		i_nrst = 1'b0;
		cyc(10);
		i_nrst = 1'b1;
		cyc(5);
		// Reset contents, with one unmapped place at each end
		for (int a = 4; a <= 17; a++) rd(8'(a), rst_of(8'(a)));
		// Drive, open drain and inversion on random settings, slow host
		host_u.stretch = 15;
		repeat (3) begin
			dv = 8'($random(seed));
			dd = 8'($random(seed));
			od = 8'($random(seed));
			pv = 8'($random(seed));
			ext = 8'($random(seed));
			wr(ADDR_POLARITY, pv);
			wr(ADDR_OPEN_DRAIN, od);
			wr(ADDR_PIN_DATA, dd);
			wr(ADDR_DIRECTION, dv);
			eo = dd ^ pv;
			ee = ~dv & (~od | ~eo);
			compare_sig("io_out", eo, io_out);
			compare_sig("io_oe", ee, io_oe);
			rd(ADDR_PIN_DATA, ((ee & eo) | (~ee & ext)) ^ pv);
		end
		host_u.stretch = 0;
		wr(ADDR_POLARITY, 8'h00);
		wr(ADDR_DIRECTION, 8'hff);
		ext = 8'hff;
		// Every edge code on some line; lines 7..4 masked
		wr(ADDR_IRQ_MASK, 8'hf0);
		wr(ADDR_SENSE_UPPER, 8'he4);
		wr(ADDR_SENSE_LOWER, 8'h1b);
		ext = 8'h00;
		cyc(12);
		compare_sig("irq_n", 8'h00, 8'(irq_n));
		rd(ADDR_EVENT_FLAGS, 8'hc3);
		rd(ADDR_IRQ_SOURCE, 8'h03);
		ext = 8'hff;
		cyc(12);
		rd(ADDR_EVENT_FLAGS, 8'he7);
		rd(ADDR_IRQ_SOURCE, 8'h07);
		// Clearing through either flag register, then by a code change
		wr(ADDR_IRQ_SOURCE, 8'h01);
		wr(ADDR_IRQ_SOURCE, 8'h00);
		rd(ADDR_EVENT_FLAGS, 8'he6);
		rd(ADDR_IRQ_SOURCE, 8'h06);
		wr(ADDR_EVENT_FLAGS, 8'h04);
		rd(ADDR_EVENT_FLAGS, 8'he2);
		rd(ADDR_IRQ_SOURCE, 8'h02);
		wr(ADDR_SENSE_LOWER, 8'h1f);
		rd(ADDR_EVENT_FLAGS, 8'he0);
		compare_sig("irq_n", 8'h01, 8'(irq_n));
		// Data read clears sources only while auto-clear is on
		ext = 8'hfe;
		cyc(12);
		rd(ADDR_PIN_DATA, 8'hfe);
		compare_sig("irq_n", 8'h01, 8'(irq_n));
		rd(ADDR_EVENT_FLAGS, 8'he1);
		wr(ADDR_MISC_CFG, 8'h01);
		ext = 8'hff;
		cyc(12);
		rd(ADDR_PIN_DATA, 8'hff);
		compare_sig("irq_n", 8'h00, 8'(irq_n));
		wr(ADDR_IRQ_SOURCE, 8'hff);
		compare_sig("irq_n", 8'h01, 8'(irq_n));
		// Plain configuration copies
		dv = 8'($random(seed));
		wr(ADDR_LEVEL_SHIFT, dv);
		compare_sig("level shift", dv, ls_mode);
		rd(ADDR_LEVEL_SHIFT, dv);
		wr(ADDR_MISC_CFG, 8'h81);
		compare_sig("fade mode", 8'h01, 8'(fade));
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_CLOCK_CFG, 8'(s << 5) | 8'h10);
			compare_sig("osc source", 8'(s), 8'(osc_src));
			compare_sig("osc pin oe", 8'h01, 8'(osc_oe));
		end
		wr(ADDR_CLOCK_CFG, 8'h00);
		compare_sig("osc pin oe", 8'h00, 8'(osc_oe));
		// Divider codes, passing through off so each code starts cleanly
		for (int n = 1; n <= 3; n++) begin
			wr(ADDR_CLOCK_CFG, 8'h10 | 8'(n));
			wr(ADDR_CLOCK_CFG, 8'h50 | 8'(n));
			period(per[n]);
		end
		compare_sig("period code 2", per[1] << 1, per[2]);
		compare_sig("period code 3", per[2] << 1, per[3]);
		wr(ADDR_CLOCK_CFG, 8'h21);
		period(dd);
		compare_sig("ext period", 8'h08, dd);
		wr(ADDR_CLOCK_CFG, 8'h10);
		wr(ADDR_CLOCK_CFG, 8'h50);
		cyc(40);
		compare_sig("clock low", 8'h00, 8'(osc_out));
		wr(ADDR_CLOCK_CFG, 8'h5f);
		cyc(40);
		compare_sig("clock high", 8'h01, 8'(osc_out));
		compare_sig("host nack", 8'h00, 8'(nack));
		compare_sig("reads left", 8'h00, 8'(exp_q.size()));
		print_verdict();
	end
endmodule // test_gxp_port
